// ---- logic/power_off_resume_alarm_control.sv ----
// power-off cause, resume/boot select, auto power-off, low_speed_idle,
// battery flags, daily alarm with wake and key-click tone
// assumes rtc time and its one-second tick come from logic on
// i_clk_sys; all pins are asynchronous and synchronised here
`timescale 1ns/1ps

// Contract
// - any reboot clears the recorded power-off cause to zero
// - boot selected for the off cause clears the cause on reboot
// - resume select: bit0 key, bit8 auto-off, bit9 soft; 1 means boot
// - resume select is all zeros after initialisation
// - resume select reads back in the same layout
// - soft-off request powers off; next power-on uses stored select
// - battery flags: bit1 main, bit2 sub, bit3 card, others zero
// - auto-off 0 disables; 1 to 15 means minutes plus 30 seconds
// - auto power-off only while power control is enabled
// - alarm set before now fires tomorrow, after now fires today
// - armed alarm interrupts every 24 hours until cleared
// - setting an alarm while one is armed gives an error
// - alarm time stored and returned unchecked
// - clear stops interrupts, keeps time and wake; re-arms at off only while wake-on-alarm is set
// - wake-on-alarm nonzero powers unit on at alarm time
// - reset-key or software reboot clears wake-on-alarm
// - power control off stops idle monitoring, no auto-off or low_speed_idle
// - idle interval with power control on enters low-speed low_speed_idle
// - soft click request makes key tone, gated by click enable
// - reset key enters the system menu
// - cause bits: 0 key, 1 reset, 3 low, 5 timeout, 8 auto, 9 soft
module power_off_resume_alarm_control
   import pm_pkg::*;
#(
   parameter int LOW_SPEED_IDLE_SEC = LOW_SPEED_IDLE_IDLE_SEC
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire pin_in_type i_pins,
   input wire rtc_time_type i_rtc_time,
   input wire logic i_rtc_tick,
   output logic o_unit_on,
   output logic o_boot,
   output logic o_resume,
   output logic o_system_menu,
   output logic o_low_speed_idle,
   output logic o_alarm_interrupt,
   output logic o_click_tone
);

   localparam int PIN_W = $bits(pin_in_type);
   localparam logic [10:0] OFF_EXTRA = 11'(AUTO_OFF_EXTRA_SEC);
   localparam logic [10:0] LOW_SPEED_IDLE_LIM = 11'(LOW_SPEED_IDLE_SEC);
   localparam logic [11:0] CLICK_LEN = 12'(CLICK_CYCLES);

   // ==========================================================
   // pin synchronisers
   logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q, fp_q, rise;
   pin_in_type pin_f, pin_rise;

   genvar g;
   generate
      for (g = 0; g < PIN_W; g++) begin : g_sync
         // a change counts once second and third stage agree
         always_ff @(posedge i_clk_sys) begin
            if (i_reset) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               f_q[g] <= 1'b0;
               fp_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= i_pins[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  f_q[g] <= s3_q[g];
               end
               fp_q[g] <= f_q[g];
            end
         end
      end
   endgenerate

   assign rise = f_q & ~fp_q;
   assign pin_f = pin_in_type'(f_q);
   assign pin_rise = pin_in_type'(rise);

   // ==========================================================
   // register bus decode
   logic wr_cmd;
   logic cmd_soft_off, cmd_clear, cmd_reboot, cmd_click, cmd_set;
   logic [15:0] resume_q, cause_q;
   logic [3:0] auto_off_q;
   logic pm_en_q, wake_q, click_en_q;
   rtc_time_type stage_q, alarm_q;
   logic armed_q, set_err_q;
   power_state_type state_q;
   logic [7:0] batt_flags;

   assign wr_cmd = i_wr && (i_addr == ADDR_CMD);
   assign cmd_soft_off = wr_cmd && i_wdata[CMD_SOFT_OFF];
   assign cmd_clear = wr_cmd && i_wdata[CMD_CLEAR_ALARM];
   assign cmd_reboot = wr_cmd && i_wdata[CMD_SOFT_REBOOT];
   assign cmd_click = wr_cmd && i_wdata[CMD_CLICK];
   assign cmd_set = wr_cmd && i_wdata[CMD_SET_ALARM];

   // battery flags straight from the filtered pins
   always_comb begin
      batt_flags = 8'h00;
      batt_flags[BATT_MAIN] = pin_f.main_battery_low;
      batt_flags[BATT_SUB] = pin_f.sub_battery_low;
      batt_flags[BATT_CARD] = pin_f.card_battery_low;
   end

   // resume select, reserved bits never stored
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         resume_q <= RESUME_RST;
      end else if (i_wr && i_addr == ADDR_RESUME) begin
         resume_q <= i_wdata & RESUME_MASK;
      end
   end

   // plain settings
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         auto_off_q <= AUTO_OFF_RST;
         pm_en_q <= PM_EN_RST;
         click_en_q <= CLICK_EN_RST;
      end else if (i_wr) begin
         if (i_addr == ADDR_AUTO_OFF) begin
            auto_off_q <= i_wdata[3:0];
         end
         if (i_addr == ADDR_PM_EN) begin
            pm_en_q <= i_wdata[0];
         end
         if (i_addr == ADDR_CLICK_EN) begin
            click_en_q <= |i_wdata;
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            ADDR_RESUME: o_rdata <= resume_q;
            ADDR_CAUSE: o_rdata <= cause_q;
            ADDR_BATT: o_rdata <= {8'h00, batt_flags};
            ADDR_AUTO_OFF: o_rdata <= {12'h000, auto_off_q};
            ADDR_PM_EN: o_rdata <= {15'h0000, pm_en_q};
            ADDR_WAKE: o_rdata <= {15'h0000, wake_q};
            ADDR_AL_HOUR: o_rdata <= {8'h00, alarm_q.hour};
            ADDR_AL_MIN: o_rdata <= {8'h00, alarm_q.minute};
            ADDR_AL_SEC: o_rdata <= {8'h00, alarm_q.second};
            ADDR_STATUS: o_rdata <= {12'h000, o_unit_on,
               o_low_speed_idle, set_err_q, armed_q};
            ADDR_CLICK_EN: o_rdata <= {15'h0000, click_en_q};
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ==========================================================
   // idle monitor: auto power-off and low_speed_idle
   logic [10:0] idle_q, auto_off_limit;
   logic idle_run, auto_off_fire;

   assign idle_run = pm_en_q && (state_q == PWR_ON);
   assign auto_off_limit = 11'(auto_off_q * SEC_PER_MIN) + OFF_EXTRA;
   // fires on the tick that completes the programmed idle time
   assign auto_off_fire = idle_run && (auto_off_q != 4'h0) && i_rtc_tick
      && (idle_q + 11'd1 == auto_off_limit);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         idle_q <= '0;
      end else if (!idle_run || pin_rise.operator_activity
         || pin_rise.key_press) begin
         idle_q <= '0;
      end else if (i_rtc_tick && idle_q != 11'h7ff) begin
         idle_q <= idle_q + 11'd1;
      end
   end

   // low_speed_idle drops on the very next input, keeping the ui responsive
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_low_speed_idle <= 1'b0;
      end else begin
         o_low_speed_idle <= idle_run && (idle_q >= LOW_SPEED_IDLE_LIM)
            && !pin_rise.operator_activity
            && !pin_rise.key_press;
      end
   end

   // ==========================================================
   // power state, cause record, wake-on-alarm
   logic match, reboot_now, go_off, go_on, boot_sel;
   logic [15:0] off_code;

   assign match = i_rtc_tick && (i_rtc_time == alarm_q);
   assign reboot_now = (state_q == PWR_ON)
      && (pin_rise.reset_key || cmd_reboot);
   assign go_on = (state_q == PWR_OFF)
      && (pin_rise.power_key || (wake_q && match));
   assign boot_sel = |(cause_q & resume_q);

   // low battery wins over operator causes
   always_comb begin
      off_code = 16'h0000;
      if (pin_rise.battery_low_off) begin
         off_code[CAUSE_BATT_OFF] = 1'b1;
      end else if (pin_rise.battery_timeout) begin
         off_code[CAUSE_BATT_TIMEOUT] = 1'b1;
      end else if (pin_rise.power_key) begin
         off_code[CAUSE_POWER_KEY] = 1'b1;
      end else if (cmd_soft_off) begin
         off_code[CAUSE_SOFT] = 1'b1;
      end else if (auto_off_fire) begin
         off_code[CAUSE_AUTO_OFF] = 1'b1;
      end
   end
   assign go_off = (state_q == PWR_ON) && !reboot_now
      && (off_code != 16'h0000);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_q <= PWR_ON;
         cause_q <= '0;
         wake_q <= 1'b0;
         o_boot <= 1'b0;
         o_resume <= 1'b0;
         o_system_menu <= 1'b0;
      end else begin
         o_boot <= 1'b0;
         o_resume <= 1'b0;
         o_system_menu <= 1'b0;
         if (i_wr && i_addr == ADDR_WAKE) begin
            wake_q <= |i_wdata;
         end
         unique case (state_q)
            PWR_ON: begin
               if (reboot_now) begin
                  // reset key goes to the menu, never seen as cause
                  o_boot <= 1'b1;
                  o_system_menu <= pin_rise.reset_key;
                  cause_q <= '0;
                  wake_q <= 1'b0;
               end else if (go_off) begin
                  state_q <= PWR_OFF;
                  cause_q <= off_code;
               end
            end
            PWR_OFF: begin
               if (go_on) begin
                  state_q <= PWR_ON;
                  if (boot_sel) begin
                     o_boot <= 1'b1;
                     cause_q <= '0;
                  end else begin
                     o_resume <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_unit_on <= 1'b1;
      end else begin
         o_unit_on <= (state_q == PWR_ON) ? !go_off : go_on;
      end
   end

   // ==========================================================
   // alarm: staging, stored time, arm and error flag
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         stage_q <= '0;
      end else if (i_wr) begin
         if (i_addr == ADDR_AL_HOUR) begin
            stage_q.hour <= i_wdata[7:0];
         end
         if (i_addr == ADDR_AL_MIN) begin
            stage_q.minute <= i_wdata[7:0];
         end
         if (i_addr == ADDR_AL_SEC) begin
            stage_q.second <= i_wdata[7:0];
         end
      end
   end

   // armed stays until cleared, so the match repeats daily
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         alarm_q <= '0;
         armed_q <= 1'b0;
      end else if (cmd_set && !armed_q) begin
         alarm_q <= stage_q;
         armed_q <= 1'b1;
      end else if (go_off && wake_q) begin
         armed_q <= 1'b1;
      end else if (cmd_clear) begin
         armed_q <= 1'b0;
      end
   end

   // error flag: set wins over the clear-on-read
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         set_err_q <= 1'b0;
      end else if (cmd_set && armed_q) begin
         set_err_q <= 1'b1;
      end else if (i_rd && i_addr == ADDR_STATUS) begin
         set_err_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_alarm_interrupt <= 1'b0;
      end else begin
         o_alarm_interrupt <= armed_q && match;
      end
   end

   // ==========================================================
   // key-click tone of fixed length
   logic [11:0] click_cnt_q;
   logic click_start;

   assign click_start = click_en_q
      && (cmd_click || pin_rise.key_press);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         click_cnt_q <= '0;
         o_click_tone <= 1'b0;
      end else if (click_start) begin
         click_cnt_q <= CLICK_LEN - 12'd1;
         o_click_tone <= 1'b1;
      end else if (click_cnt_q != 12'h000) begin
         click_cnt_q <= click_cnt_q - 12'd1;
      end else begin
         o_click_tone <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   sequence s_soft_off_req;
      state_q == PWR_ON && cmd_soft_off && !reboot_now
         && off_code == 16'h0200;
   endsequence
   sequence s_powered_down;
      !o_unit_on && cause_q[CAUSE_SOFT] && state_q == PWR_OFF;
   endsequence
   sequence s_reset_key_reboot;
      state_q == PWR_ON && pin_rise.reset_key;
   endsequence

   a_boot_clears_cause: assert property (
      o_boot |-> cause_q == 16'h0000)
      else $error("cause not cleared at boot");
   a_resume_default: assert property (
      $fell(i_reset) |-> resume_q == 16'h0000)
      else $error("resume select not zero after reset");
   a_resume_readback: assert property (
      i_rd && i_addr == ADDR_RESUME |=> o_rdata == resume_q)
      else $error("resume select readback wrong");
   a_soft_power_off: assert property (
      s_soft_off_req |=> s_powered_down)
      else $error("soft off did not power down");
   a_auto_off_enable: assert property (
      go_off && off_code[CAUSE_AUTO_OFF]
         |-> pm_en_q && auto_off_q != 4'h0)
      else $error("auto off without enable");
   a_low_speed_idle_gated: assert property (
      !pm_en_q ##1 !pm_en_q |-> !o_low_speed_idle)
      else $error("low_speed_idle while power control off");
   a_alarm_reject: assert property (
      cmd_set && armed_q |=> set_err_q && $stable(alarm_q))
      else $error("alarm set not rejected");
   a_alarm_repeat: assert property (
      armed_q && match |=> o_alarm_interrupt)
      else $error("armed alarm did not interrupt");
   a_clear_keeps_time: assert property (
      cmd_clear && !cmd_set && !go_off && !reboot_now
         |=> !armed_q && $stable(alarm_q) && $stable(wake_q))
      else $error("alarm clear wrong");
   a_wake_on_alarm: assert property (
      state_q == PWR_OFF && wake_q && match |=> o_unit_on)
      else $error("alarm did not wake unit");
   a_reset_key_menu: assert property (
      s_reset_key_reboot |=> o_system_menu && o_boot && !wake_q)
      else $error("reset key reboot wrong");
   a_click_length: assert property (
      click_start |=> o_click_tone [*8])
      else $error("click tone too short");

endmodule

// ---- logic/pm_pkg.sv ----
// package for the power-off / resume / alarm control block
// assumes one 100 MHz clock and a one-second tick from the rtc
package pm_pkg;

   // ==========================================================
   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_RESUME = 4'h1;
   localparam logic [3:0] ADDR_CAUSE = 4'h2;
   localparam logic [3:0] ADDR_BATT = 4'h3;
   localparam logic [3:0] ADDR_AUTO_OFF = 4'h4;
   localparam logic [3:0] ADDR_PM_EN = 4'h5;
   localparam logic [3:0] ADDR_WAKE = 4'h6;
   localparam logic [3:0] ADDR_AL_HOUR = 4'h7;
   localparam logic [3:0] ADDR_AL_MIN = 4'h8;
   localparam logic [3:0] ADDR_AL_SEC = 4'h9;
   localparam logic [3:0] ADDR_STATUS = 4'ha;
   localparam logic [3:0] ADDR_CLICK_EN = 4'hb;

   // ==========================================================
   // command bits (write-only pulses)
   localparam int CMD_SOFT_OFF = 0;
   localparam int CMD_CLEAR_ALARM = 1;
   localparam int CMD_SOFT_REBOOT = 2;
   localparam int CMD_CLICK = 3;
   localparam int CMD_SET_ALARM = 4;

   // ==========================================================
   // power-off cause bits, resume select uses the same positions
   localparam int CAUSE_POWER_KEY = 0;
   localparam int CAUSE_RESET_KEY = 1;
   localparam int CAUSE_BATT_OFF = 3;
   localparam int CAUSE_BATT_TIMEOUT = 5;
   localparam int CAUSE_AUTO_OFF = 8;
   localparam int CAUSE_SOFT = 9;
   localparam logic [15:0] RESUME_MASK = 16'h0301;
   localparam logic [15:0] RESUME_RST = 16'h0000;

   // battery flag bits and status bits
   localparam int BATT_MAIN = 1;
   localparam int BATT_SUB = 2;
   localparam int BATT_CARD = 3;
   localparam int STAT_ARMED = 0;
   localparam int STAT_SET_ERR = 1;
   localparam int STAT_LOW_SPEED_IDLE = 2;
   localparam int STAT_ON = 3;

   // reset values of settings
   localparam logic PM_EN_RST = 1'b1;
   localparam logic CLICK_EN_RST = 1'b1;
   localparam logic [3:0] AUTO_OFF_RST = 4'h0;

   // ==========================================================
   // timing
   localparam int SEC_PER_MIN = 60;
   localparam int AUTO_OFF_EXTRA_SEC = 30;
   localparam int LOW_SPEED_IDLE_IDLE_SEC = 16;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLICK_TIME_NS = 20000;
   localparam int CLICK_CYCLES = CLICK_TIME_NS / CLK_PERIOD_NS;

   // ==========================================================
   // types
   typedef struct packed {
      logic power_key;
      logic reset_key;
      logic battery_low_off;
      logic battery_timeout;
      logic main_battery_low;
      logic sub_battery_low;
      logic card_battery_low;
      logic operator_activity;
      logic key_press;
   } pin_in_type;

   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } rtc_time_type;

   typedef enum logic {PWR_OFF, PWR_ON} power_state_type;

endpackage

// ---- sim/test_power_off_resume_alarm_control.sv ----
// self-checking bench for the power-off / resume / alarm block
// assumes the block's own assertions run inside it; the bench drives
// the register port, the pins, the rtc time and its one-second tick
`timescale 1ns/1ps
module test_power_off_resume_alarm_control
   import pm_pkg::*;
;
   // ==========================================================
   // clock, stimulus and observation
   localparam int LIMIT = 20000;
   localparam int PK = 8;
   localparam int RK = 7;
   localparam int ACT = 1;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [DATA_W-1:0] o_rdata;
   pin_in_type pins = '0;
   rtc_time_type rtc = '0;
   logic tick = 1'b0;
   logic o_unit_on, o_boot, o_resume, o_system_menu;
   logic o_low_speed_idle, o_alarm_interrupt, o_click_tone;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_boot = 0, n_resume = 0, n_menu = 0, n_irq = 0;
   int b0, b1, b2, b3;
   logic [15:0] d;

   always #5 i_clk_sys = ~i_clk_sys;

   // low_speed_idle threshold shortened so the idle path is reached quickly
   power_off_resume_alarm_control #(.LOW_SPEED_IDLE_SEC(2)) uut (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_pins(pins), .i_rtc_time(rtc), .i_rtc_tick(tick),
      .o_unit_on(o_unit_on), .o_boot(o_boot), .o_resume(o_resume),
      .o_system_menu(o_system_menu), .o_low_speed_idle(o_low_speed_idle),
      .o_alarm_interrupt(o_alarm_interrupt), .o_click_tone(o_click_tone));

   // pulse counters, so a one-cycle pulse is never missed by a test
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (o_boot === 1'b1) n_boot <= n_boot + 1;
      if (o_resume === 1'b1) n_resume <= n_resume + 1;
      if (o_system_menu === 1'b1) n_menu <= n_menu + 1;
      if (o_alarm_interrupt === 1'b1) n_irq <= n_irq + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         end_of_test();
      end
   end

   // ==========================================================
   // access tasks and comparisons
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clk_sys);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge i_clk_sys);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask

   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      check_reg(v, exp);
   endtask

   // pins pass a synchroniser, so hold well beyond its depth
   task automatic press(input int idx);
      @(posedge i_clk_sys);
      pins[idx] <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      pins[idx] <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         tick <= 1'b1;
         @(posedge i_clk_sys);
         tick <= 1'b0;
      end
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic snap();
      b0 = n_boot; b1 = n_resume; b2 = n_menu; b3 = n_irq;
   endtask

   task automatic end_of_test();
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      // settings after initialisation
      rdchk(ADDR_RESUME, 16'h0000);
      rdchk(ADDR_CAUSE, 16'h0000);
      rdchk(ADDR_PM_EN, 16'h0001);
      rdchk(ADDR_STATUS, 16'h0008);
      rdchk(4'hf, 16'h0000);
      wr(4'hf, 16'hffff);
      wr(ADDR_CAUSE, 16'hffff);
      rdchk(ADDR_CAUSE, 16'h0000);
      // reserved select bits dropped, same layout on readback
      wr(ADDR_RESUME, 16'hffff);
      rdchk(ADDR_RESUME, 16'h0301);
      wr(ADDR_RESUME, 16'h0000);
      rdchk(ADDR_RESUME, 16'h0000);
      // battery flags
      pins.main_battery_low <= 1'b1;
      pins.sub_battery_low <= 1'b1;
      pins.card_battery_low <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      rdchk(ADDR_BATT, 16'h000e);
      pins.main_battery_low <= 1'b0;
      pins.card_battery_low <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      rdchk(ADDR_BATT, 16'h0004);
      // software off then resume on power key
      snap();
      wr(ADDR_CMD, 16'h0001);
      #1 check_bit(o_unit_on, 1'b0);
      rdchk(ADDR_CAUSE, 16'h0200);
      press(PK);
      check_bit(o_unit_on, 1'b1);
      check_cnt(n_resume - b1, 1);
      check_cnt(n_boot - b0, 0);
      // power key off, then on
      press(PK);
      check_bit(o_unit_on, 1'b0);
      rdchk(ADDR_CAUSE, 16'h0001);
      press(PK);
      check_cnt(n_resume - b1, 2);
      // boot selected for software off clears the cause
      wr(ADDR_RESUME, 16'h0200);
      wr(ADDR_CMD, 16'h0001);
      press(PK);
      check_cnt(n_boot - b0, 1);
      rdchk(ADDR_CAUSE, 16'h0000);
      wr(ADDR_RESUME, 16'h0000);
      // software reboot clears wake-on-alarm
      wr(ADDR_WAKE, 16'h0040);
      rdchk(ADDR_WAKE, 16'h0001);
      wr(ADDR_CMD, 16'h0004);
      rdchk(ADDR_WAKE, 16'h0000);
      check_cnt(n_boot - b0, 2);
      // reset key reboots into the system menu
      wr(ADDR_WAKE, 16'h0001);
      press(RK);
      check_cnt(n_menu - b2, 1);
      check_cnt(n_boot - b0, 3);
      check_bit(o_unit_on, 1'b1);
      rdchk(ADDR_WAKE, 16'h0000);
      // alarm with a time that is not a valid clock time
      rtc <= '{8'h25, 8'h61, 8'h70};
      wr(ADDR_AL_HOUR, 16'h0025);
      wr(ADDR_AL_MIN, 16'h0061);
      wr(ADDR_AL_SEC, 16'h0070);
      wr(ADDR_CMD, 16'h0010);
      rdchk(ADDR_AL_HOUR, 16'h0025);
      rdchk(ADDR_AL_SEC, 16'h0070);
      rdchk(ADDR_STATUS, 16'h0009);
      wr(ADDR_CMD, 16'h0010);
      rdchk(ADDR_STATUS, 16'h000b);
      rdchk(ADDR_STATUS, 16'h0009);
      snap();
      ticks(1);
      check_cnt(n_irq - b3, 1);
      rtc.second <= 8'h71;
      ticks(1);
      check_cnt(n_irq - b3, 1);
      rtc.second <= 8'h70;
      ticks(1);
      check_cnt(n_irq - b3, 2);
      wr(ADDR_CMD, 16'h0002);
      ticks(1);
      check_cnt(n_irq - b3, 2);
      rd(ADDR_STATUS, d);
      check_reg(d & 16'h000b, 16'h0008);
      rdchk(ADDR_AL_MIN, 16'h0061);
      // wake-on-alarm re-arms at power-off and powers the unit on
      wr(ADDR_WAKE, 16'h0001);
      wr(ADDR_CMD, 16'h0001);
      rd(ADDR_STATUS, d);
      check_reg(d & 16'h000b, 16'h0001);
      ticks(1);
      check_bit(o_unit_on, 1'b1);
      check_cnt(n_irq - b3, 3);
      wr(ADDR_CMD, 16'h0002);
      wr(ADDR_WAKE, 16'h0000);
      // power control disabled: no low_speed_idle, no auto-off
      rtc <= '{8'h00, 8'h00, 8'h00};
      wr(ADDR_PM_EN, 16'h0000);
      wr(ADDR_AUTO_OFF, 16'h0001);
      ticks(100);
      check_bit(o_unit_on, 1'b1);
      check_bit(o_low_speed_idle, 1'b0);
      // enabled: low_speed_idle after the idle interval, cleared by activity
      wr(ADDR_PM_EN, 16'h0001);
      press(ACT);
      ticks(2);
      check_bit(o_low_speed_idle, 1'b1);
      press(ACT);
      check_bit(o_low_speed_idle, 1'b0);
      // one minute plus thirty seconds, boundary on both sides
      ticks(89);
      check_bit(o_unit_on, 1'b1);
      ticks(1);
      check_bit(o_unit_on, 1'b0);
      rdchk(ADDR_CAUSE, 16'h0100);
      press(PK);
      wr(ADDR_AUTO_OFF, 16'h0000);
      rdchk(ADDR_AUTO_OFF, 16'h0000);
      // click tone from software, gated by the click setting
      wr(ADDR_CMD, 16'h0008);
      #1 check_bit(o_click_tone, 1'b1);
      repeat (CLICK_CYCLES + 2) @(posedge i_clk_sys);
      #1 check_bit(o_click_tone, 1'b0);
      wr(ADDR_CLICK_EN, 16'h0000);
      wr(ADDR_CMD, 16'h0008);
      repeat (2) @(posedge i_clk_sys);
      #1 check_bit(o_click_tone, 1'b0);
      end_of_test();
   end
endmodule
